// File: logic/mdc_pkg.sv
package mdc_pkg;
  // bus geometry; printed offsets are word indices, byte address is four times the index
  localparam int          ADDR_W       = 14;
  localparam logic [11:0] DEV_CFG_IDX  = 12'h0A8;
  localparam logic [11:0] PERI_CFG_IDX = 12'h0AA;
  localparam logic [11:0] STATUS_IDX   = 12'h0F0;
  // reset values and writable masks
  localparam logic [31:0] DEV_CFG_RST   = 32'h00000000;
  localparam logic [31:0] PERI_CFG_RST  = 32'h40000000;
  localparam logic [31:0] DEV_CFG_MASK  = 32'h7FFFFFFF;
  localparam logic [31:0] PERI_CFG_MASK = 32'h43E00000;
  // field codes
  localparam logic [1:0]  CLK_SEL_EXT     = 2'h3;
  localparam logic [1:0]  SPEED_MODE_FREQ = 2'h3;
  localparam logic [3:0]  LIMIT_CODE_MAX  = 4'hD;
  localparam logic [8:0]  LIMIT_CODE0     = 9'h00A;
  localparam logic [8:0]  LIMIT_CODE1     = 9'h014;
  localparam logic [8:0]  LIMIT_STEP      = 9'h028;
  localparam logic [10:0] EXT_RATE_BASE   = 11'h008;
  localparam int          DUTY_W          = 16;
  localparam logic [4:0]  DIV_STEPS       = 5'h10;
  // timing, in printed units, and derived cycle counts
  localparam longint CLK_MHZ      = 250;
  localparam longint SLEEP_T0_US  = 50;
  localparam longint SLEEP_T1_US  = 200;
  localparam longint SLEEP_T2_MS  = 20;
  localparam longint SLEEP_T3_MS  = 200;
  localparam longint WDT_PIN_T0_MS = 100;
  localparam longint WDT_PIN_T1_MS = 200;
  localparam longint WDT_PIN_T2_MS = 500;
  localparam longint WDT_PIN_T3_MS = 1000;
  localparam longint WDT_BUS_T0_S  = 1;
  localparam longint WDT_BUS_T1_S  = 2;
  localparam longint WDT_BUS_T2_S  = 3;
  localparam longint WDT_BUS_T3_S  = 10;
  localparam logic [31:0] SLEEP_CYC0 = 32'(SLEEP_T0_US * CLK_MHZ);
  localparam logic [31:0] SLEEP_CYC1 = 32'(SLEEP_T1_US * CLK_MHZ);
  localparam logic [31:0] SLEEP_CYC2 = 32'(SLEEP_T2_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] SLEEP_CYC3 = 32'(SLEEP_T3_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] WDT_PIN_CYC0 = 32'(WDT_PIN_T0_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] WDT_PIN_CYC1 = 32'(WDT_PIN_T1_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] WDT_PIN_CYC2 = 32'(WDT_PIN_T2_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] WDT_PIN_CYC3 = 32'(WDT_PIN_T3_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] WDT_BUS_CYC0 = 32'(WDT_BUS_T0_S * 1000000 * CLK_MHZ);
  localparam logic [31:0] WDT_BUS_CYC1 = 32'(WDT_BUS_T1_S * 1000000 * CLK_MHZ);
  localparam logic [31:0] WDT_BUS_CYC2 = 32'(WDT_BUS_T2_S * 1000000 * CLK_MHZ);
  localparam logic [31:0] WDT_BUS_CYC3 = 32'(WDT_BUS_T3_S * 1000000 * CLK_MHZ);

  typedef struct packed {
    logic        rsvd;
    logic [14:0] max_freq;
    logic [1:0]  sleep_time;
    logic        auto_current_amp_gain_on;
    logic        auto_volt_gain_on;
    logic        low_power_state_select;
    logic [1:0]  clk_sel;
    logic        outside_timebase_on;
    logic [2:0]  outside_timebase_rate;
    logic        host_watchdog_on;
    logic [1:0]  host_watchdog_interval;
    logic        host_watchdog_source;
    logic        host_watchdog_fault_action;
  } mdc_dev_cfg_t;

  typedef struct packed {
    logic        rsvd_top;
    logic        freq_dither_off;
    logic [3:0]  rsvd_mid;
    logic [3:0]  bus_limit_code;
    logic        bus_limit_on;
    logic [20:0] rsvd_low;
  } mdc_peri_cfg_t;

  typedef struct packed {
    logic sleep_req;
    logic wdt_hiz;
    logic wdt_fault_seen;
  } mdc_stat_t;
endpackage

// File: logic/mdc_regs.sv
`timescale 1ns/1ps
// Contract
// [R1] frequency mode duty equals measured frequency divided by maximum-frequency field
// [R2] sleep after reference held low for 50us, 200us, 20ms or 200ms
// [R3] automatic current amplifier gain follows its enable bit
// [R4] automatic voltage gain follows its enable bit
// [R5] low-power select: 0 standby, 1 sleep
// [R6] clock source code 0 internal, 3 external, 1 and 2 reserved
// [R7] separate enable bit switches external clock mode
// [R8] external reference rate is 8 kHz times two to the code
// [R9] watchdog supervised only while its enable bit is set
// [R10] host tickles within 100ms..1000ms pin or 1s..10s bus interval
// [R11] watchdog source 0 bus transactions, 1 input pin
// [R12] fault action 0 reports only, 1 latches switches high-impedance
// [R13] dither disable bit: 0 dither on, 1 off, resets to 1
// [R14] bus current limit code sets threshold, codes E and F reserved
// [R15] bus current limit applied only while its enable is 1
// [R16] peripheral configuration at index AA, reset 40000000
// [R17] frequency scaling applies only when reference mode is code 3
// [R18] device configuration at index A8, reset zero
// [R19] reserved bits read zero and ignore writes
// [R20] tickle restarts interval timer, expiry without tickle raises fault
module mdc_regs #(
  parameter logic [3:0][31:0] SLEEP_CYC = {mdc_pkg::SLEEP_CYC3, mdc_pkg::SLEEP_CYC2,
                                           mdc_pkg::SLEEP_CYC1, mdc_pkg::SLEEP_CYC0},
  parameter logic [3:0][31:0] WDT_PIN_CYC = {mdc_pkg::WDT_PIN_CYC3, mdc_pkg::WDT_PIN_CYC2,
                                             mdc_pkg::WDT_PIN_CYC1, mdc_pkg::WDT_PIN_CYC0},
  parameter logic [3:0][31:0] WDT_BUS_CYC = {mdc_pkg::WDT_BUS_CYC3, mdc_pkg::WDT_BUS_CYC2,
                                             mdc_pkg::WDT_BUS_CYC1, mdc_pkg::WDT_BUS_CYC0}
) (
  input  wire logic                         core_clk,         // device clock
  input  wire logic                         rst,              // async reset, high
  input  wire logic [mdc_pkg::ADDR_W-1:0]   avs_address,      // byte address
  input  wire logic                         avs_read,         // read request
  input  wire logic                         avs_write,        // write request
  input  wire logic [31:0]                  avs_writedata,    // write data
  output logic      [31:0]                  avs_readdata,     // read data
  output logic                              avs_waitrequest,  // stall
  input  wire logic                         rate_ref_low_pin, // reference below threshold
  input  wire logic                         wdt_tickle_pin,   // tickle input pin
  input  wire logic                         bus_tickle,       // tickle transaction pulse
  input  wire logic [1:0]                   speed_mode,       // reference input mode
  input  wire logic [14:0]                  meas_freq,        // measured input frequency
  input  wire logic                         meas_strobe,      // new measurement pulse
  output mdc_pkg::mdc_dev_cfg_t             dev_cfg,          // device config fields
  output mdc_pkg::mdc_peri_cfg_t            peri_cfg,         // peripheral fields
  output mdc_pkg::mdc_stat_t                status,           // status flags
  output logic [mdc_pkg::DUTY_W-1:0]        duty,             // duty fraction
  output logic                              duty_valid,       // duty update pulse
  output logic                              ext_clk_used,     // external timebase active
  output logic [10:0]                       ext_rate_khz,     // declared rate in kHz
  output logic                              dither_on,        // dither running
  output logic                              bus_limit_on,     // limiter active
  output logic [8:0]                        bus_limit_th,     // threshold, 1/128 A
  output logic                              enter_sleep,      // go to sleep
  output logic                              wdt_fault_pulse,  // fault report pulse
  output logic                              switches_hiz      // power switches off
);
  mdc_pkg::mdc_dev_cfg_t  dev_q;
  mdc_pkg::mdc_peri_cfg_t peri_q;
  mdc_pkg::mdc_stat_t     stat_q;
  logic [31:0] rdata_q;
  logic        wait_q;
  logic [1:0]  ref_sync_q;
  logic        sleep_q;
  logic        dither_q;
  logic [2:0]  tick_sync_q;
  logic [31:0] sleep_cnt_q;
  logic [31:0] wdt_cnt_q;
  logic        fault_pulse_q;
  logic        ext_q;
  logic [10:0] rate_q;
  logic [8:0]  th_q;
  logic        busy_q;
  logic [4:0]  step_q;
  logic [15:0] rem_q;
  logic [15:0] quo_q;
  logic [15:0] duty_q;
  logic        dvalid_q;
  logic        wr_go;
  logic        wdt_tick;
  logic        wdt_expire;
  logic [31:0] wdt_lim;
  logic [16:0] rem_sh;

  function automatic logic hit(input logic [mdc_pkg::ADDR_W-1:0] a, input logic [11:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  assign wr_go = avs_write && !wait_q;
  assign wdt_lim = dev_q.host_watchdog_source ? WDT_PIN_CYC[dev_q.host_watchdog_interval]
                                              : WDT_BUS_CYC[dev_q.host_watchdog_interval];
  assign wdt_tick = dev_q.host_watchdog_source ? (tick_sync_q[1] && !tick_sync_q[2]) : bus_tickle; // R11
  assign wdt_expire = dev_q.host_watchdog_on && !wdt_tick && (wdt_cnt_q == wdt_lim - 32'h00000001);
  assign rem_sh = {rem_q, 1'b0};

  // one wait cycle, then answer for one cycle
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      wait_q <= 1'b1;
    else
      wait_q <= !((avs_read || avs_write) && wait_q);

  // read mux, reserved and unmapped read zero
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      rdata_q <= 32'h00000000;
    else if (avs_read && wait_q)
    begin
      if (hit(avs_address, mdc_pkg::DEV_CFG_IDX))
        rdata_q <= dev_q & mdc_pkg::DEV_CFG_MASK; // R19
      else if (hit(avs_address, mdc_pkg::PERI_CFG_IDX))
        rdata_q <= peri_q & mdc_pkg::PERI_CFG_MASK; // R19
      else if (hit(avs_address, mdc_pkg::STATUS_IDX))
        rdata_q <= {29'h00000000, stat_q};
      else
        rdata_q <= 32'h00000000;
    end

  // device configuration register
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      dev_q <= mdc_pkg::DEV_CFG_RST; // R18
    else if (wr_go && hit(avs_address, mdc_pkg::DEV_CFG_IDX)) // R18
      dev_q <= avs_writedata & mdc_pkg::DEV_CFG_MASK; // R19 R3 R4 R5

  // peripheral configuration register
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      peri_q <= mdc_pkg::PERI_CFG_RST; // R16 R13
    else if (wr_go && hit(avs_address, mdc_pkg::PERI_CFG_IDX)) // R16
      peri_q <= avs_writedata & mdc_pkg::PERI_CFG_MASK; // R19

  // derived clock and limiter settings
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      ext_q  <= 1'b0;
      dither_q <= 1'b0;
      rate_q <= mdc_pkg::EXT_RATE_BASE;
      th_q   <= mdc_pkg::LIMIT_CODE0;
    end
    else
    begin
      ext_q  <= dev_q.outside_timebase_on && (dev_q.clk_sel == mdc_pkg::CLK_SEL_EXT); // R6 R7
      dither_q <= !peri_q.freq_dither_off; // R13
      rate_q <= mdc_pkg::EXT_RATE_BASE << dev_q.outside_timebase_rate; // R8
      if (peri_q.bus_limit_code == 4'h0)
        th_q <= mdc_pkg::LIMIT_CODE0; // R14
      else if (peri_q.bus_limit_code == 4'h1)
        th_q <= mdc_pkg::LIMIT_CODE1;
      else if (peri_q.bus_limit_code > mdc_pkg::LIMIT_CODE_MAX)
        th_q <= 9'(mdc_pkg::LIMIT_STEP * 4'(mdc_pkg::LIMIT_CODE_MAX - 4'h1)); // reserved: clamp
      else
        th_q <= 9'(mdc_pkg::LIMIT_STEP * 4'(peri_q.bus_limit_code - 4'h1)); // R14
    end

  // pin synchronisers plus one edge stage
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      ref_sync_q  <= 2'h0;
      tick_sync_q <= 3'h0;
    end
    else
    begin
      ref_sync_q  <= {ref_sync_q[0], rate_ref_low_pin};
      tick_sync_q <= {tick_sync_q[1:0], wdt_tickle_pin};
    end

  // continuous-low timer for sleep entry
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      sleep_cnt_q <= 32'h00000000;
      sleep_q     <= 1'b0;
    end
    else if (!ref_sync_q[1])
    begin
      sleep_cnt_q <= 32'h00000000;
      sleep_q     <= 1'b0;
    end
    else if (!sleep_q)
    begin
      if (sleep_cnt_q >= SLEEP_CYC[dev_q.sleep_time] - 32'h00000001) // R2
        sleep_q <= 1'b1;
      else
        sleep_cnt_q <= sleep_cnt_q + 32'h00000001;
    end

  // watchdog interval timer
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      wdt_cnt_q <= 32'h00000000;
    else if (!dev_q.host_watchdog_on || wdt_tick || wdt_expire) // R9 R20
      wdt_cnt_q <= 32'h00000000;
    else
      wdt_cnt_q <= wdt_cnt_q + 32'h00000001; // R10

  // fault flags, set wins over a write-one clear
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      fault_pulse_q <= 1'b0;
      stat_q.wdt_fault_seen <= 1'b0;
      stat_q.wdt_hiz <= 1'b0;
      stat_q.sleep_req <= 1'b0;
    end
    else
    begin
      fault_pulse_q <= wdt_expire; // R20
      stat_q.sleep_req <= sleep_q; // R2
      if (wdt_expire)
        stat_q.wdt_fault_seen <= 1'b1;
      else if (wr_go && hit(avs_address, mdc_pkg::STATUS_IDX) && avs_writedata[0])
        stat_q.wdt_fault_seen <= 1'b0;
      if (wdt_expire && dev_q.host_watchdog_fault_action) // R12
        stat_q.wdt_hiz <= 1'b1;
      else if (wr_go && hit(avs_address, mdc_pkg::STATUS_IDX) && avs_writedata[1])
        stat_q.wdt_hiz <= 1'b0;
    end

  // serial divider: duty = measured / maximum, 16 fraction bits
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      busy_q   <= 1'b0;
      step_q   <= 5'h00;
      rem_q    <= 16'h0000;
      quo_q    <= 16'h0000;
      duty_q   <= 16'h0000;
      dvalid_q <= 1'b0;
    end
    else
    begin
      dvalid_q <= 1'b0;
      if (!busy_q)
      begin
        if (meas_strobe && speed_mode == mdc_pkg::SPEED_MODE_FREQ) // R17
        begin
          if (meas_freq >= dev_q.max_freq) // full command or zero maximum
          begin
            duty_q   <= 16'hFFFF;
            dvalid_q <= 1'b1;
          end
          else
          begin
            busy_q <= 1'b1;
            step_q <= mdc_pkg::DIV_STEPS;
            rem_q  <= {1'b0, meas_freq};
            quo_q  <= 16'h0000;
          end
        end
      end
      else
      begin
        if (rem_sh >= {2'b00, dev_q.max_freq}) // R1
        begin
          rem_q <= 16'(rem_sh - {2'b00, dev_q.max_freq});
          quo_q <= {quo_q[14:0], 1'b1};
        end
        else
        begin
          rem_q <= rem_sh[15:0];
          quo_q <= {quo_q[14:0], 1'b0};
        end
        step_q <= step_q - 5'h01;
        if (step_q == 5'h01)
        begin
          busy_q   <= 1'b0;
          dvalid_q <= 1'b1;
          duty_q   <= {quo_q[14:0], rem_sh >= {2'b00, dev_q.max_freq}};
        end
      end
    end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign dev_cfg         = dev_q;
  assign peri_cfg        = peri_q;
  assign status          = stat_q;
  assign duty            = duty_q;
  assign duty_valid      = dvalid_q;
  assign ext_clk_used    = ext_q;
  assign ext_rate_khz    = rate_q;
  assign dither_on       = dither_q; // R13
  assign bus_limit_on    = peri_q.bus_limit_on; // R15
  assign bus_limit_th    = th_q;
  assign enter_sleep     = sleep_q; // R2
  assign wdt_fault_pulse = fault_pulse_q;
  assign switches_hiz    = stat_q.wdt_hiz; // R12

  sequence s_req_taken;
    (avs_read || avs_write) && wait_q;
  endsequence
  sequence s_answer;
    !wait_q ##1 wait_q;
  endsequence

  chk_bus_answer_once: assert property (@(posedge core_clk) disable iff (rst) // R19
    s_req_taken |=> s_answer) else $error("bus answer not one cycle");
  chk_reserved_read_zero: assert property (@(posedge core_clk) disable iff (rst) // R19
    avs_read && wait_q && hit(avs_address, mdc_pkg::DEV_CFG_IDX) |=> !rdata_q[31])
    else $error("reserved bit read nonzero");
  chk_peri_write_mask: assert property (@(posedge core_clk) disable iff (rst) // R16
    wr_go && hit(avs_address, mdc_pkg::PERI_CFG_IDX) |=> peri_q == (mdc_pkg::PERI_CFG_MASK & $past(avs_writedata)))
    else $error("peripheral write wrong");
  chk_dither_sense: assert property (@(posedge core_clk) disable iff (rst) // R13
    ##1 dither_on != $past(peri_q.freq_dither_off)) else $error("dither sense wrong");
  chk_ext_clock_mode: assert property (@(posedge core_clk) disable iff (rst) // R6
    ##1 ext_q == ($past(dev_q.outside_timebase_on) && $past(dev_q.clk_sel) == 2'h3))
    else $error("external clock select wrong");
  chk_rate_decode: assert property (@(posedge core_clk) disable iff (rst) // R8
    $stable(dev_q.outside_timebase_rate) |=> rate_q == (11'h008 << $past(dev_q.outside_timebase_rate)))
    else $error("external rate wrong");
  chk_sleep_needs_low: assert property (@(posedge core_clk) disable iff (rst) // R2
    !ref_sync_q[1] |=> !sleep_q) else $error("sleep without low input");
  chk_sleep_entry_time: assert property (@(posedge core_clk) disable iff (rst) // R2
    $rose(sleep_q) |-> sleep_cnt_q == SLEEP_CYC[dev_q.sleep_time] - 32'h00000001)
    else $error("sleep entered at wrong time");
  chk_wdt_disabled: assert property (@(posedge core_clk) disable iff (rst) // R9
    !dev_q.host_watchdog_on |-> !wdt_expire ##1 !fault_pulse_q) else $error("fault while disabled");
  chk_fault_latch: assert property (@(posedge core_clk) disable iff (rst) // R12
    wdt_expire |=> fault_pulse_q && stat_q.wdt_fault_seen && (stat_q.wdt_hiz || !$past(dev_q.host_watchdog_fault_action)))
    else $error("fault response wrong");
  chk_tickle_restart: assert property (@(posedge core_clk) disable iff (rst) // R20
    dev_q.host_watchdog_on && wdt_tick |=> wdt_cnt_q == 32'h00000000) else $error("tickle did not restart");
  chk_divide_length: assert property (@(posedge core_clk) disable iff (rst) // R1
    $rose(busy_q) |-> busy_q [*8] ##9 (!busy_q && dvalid_q)) else $error("divide length wrong");
endmodule

// File: testbench/mdc_host_model.sv
`timescale 1ns/1ps
// host side: periodic watchdog tickles on pin or bus
module mdc_host_model (
  input  wire logic        core_clk, // device clock
  input  wire logic        run,      // tickling active
  input  wire logic        use_pin,  // tickle by pin, else bus
  input  wire logic [15:0] period,   // cycles between tickles
  output logic             tick_pin, // tickle pin level
  output logic             tick_bus  // tickle transaction pulse
);
  logic [15:0] cnt_q;
  // quiet lines at time zero
  initial
  begin
    tick_pin = 1'b0;
    tick_bus = 1'b0;
    cnt_q = 16'h0000;
  end
  // one tickle per period, well inside the interval
  always @(posedge core_clk)
  begin
    tick_bus <= 1'b0;
    if (!run)
    begin
      cnt_q <= 16'h0000;
      tick_pin <= 1'b0;
    end
    else if (cnt_q >= period)
    begin
      cnt_q <= 16'h0000;
      tick_pin <= use_pin;
      tick_bus <= !use_pin;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      if (cnt_q == 16'h0002)
        tick_pin <= 1'b0;
    end
  end
endmodule

// File: testbench/motor_driver_device_config_regs_tb.sv
`timescale 1ns/1ps
module motor_driver_device_config_regs_tb;
  localparam logic [3:0][31:0] s_cyc = {32'h28, 32'h1E, 32'h14, 32'h0A};
  localparam logic [3:0][31:0] p_cyc = {32'h50, 32'h3C, 32'h28, 32'h1E};
  localparam logic [3:0][31:0] b_cyc = {32'h78, 32'h64, 32'h46, 32'h32};
  localparam logic [13:0] a_dev  = {mdc_pkg::DEV_CFG_IDX, 2'b00};
  localparam logic [13:0] a_peri = {mdc_pkg::PERI_CFG_IDX, 2'b00};
  localparam logic [13:0] a_stat = {mdc_pkg::STATUS_IDX, 2'b00};
  logic                   core_clk = 1'b0;
  logic                   rst = 1'b1;
  logic [13:0]            avs_address = 14'h0000;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [31:0]            avs_writedata = 32'h00000000;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   ref_low = 1'b0;
  logic [1:0]             speed_mode = 2'h0;
  logic [14:0]            meas_freq = 15'h0000;
  logic                   meas_strobe = 1'b0;
  mdc_pkg::mdc_dev_cfg_t  dev_cfg;
  mdc_pkg::mdc_peri_cfg_t peri_cfg;
  mdc_pkg::mdc_stat_t     status;
  logic [15:0]            duty;
  logic                   duty_valid, ext_clk_used, dither_on, bus_limit_on;
  logic [10:0]            ext_rate_khz;
  logic [8:0]             bus_limit_th;
  logic                   enter_sleep, wdt_fault_pulse, switches_hiz;
  logic                   host_run = 1'b0;
  logic                   host_pin = 1'b0;
  logic [15:0]            host_per = 16'h0010;
  logic                   tick_pin, tick_bus;
  logic [31:0]            seed = 32'h41BFBD62;
  logic [31:0]            q, v;
  int                     failures = 0;
  int                     comparisons = 0;
  int                     pulses = 0;
  int                     n, lim;
  longint                 e;

  mdc_regs #(.SLEEP_CYC(s_cyc), .WDT_PIN_CYC(p_cyc), .WDT_BUS_CYC(b_cyc)) i_mdc_regs (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rate_ref_low_pin(ref_low), .wdt_tickle_pin(tick_pin),
    .bus_tickle(tick_bus), .speed_mode(speed_mode), .meas_freq(meas_freq),
    .meas_strobe(meas_strobe), .dev_cfg(dev_cfg), .peri_cfg(peri_cfg), .status(status),
    .duty(duty), .duty_valid(duty_valid), .ext_clk_used(ext_clk_used),
    .ext_rate_khz(ext_rate_khz), .dither_on(dither_on), .bus_limit_on(bus_limit_on),
    .bus_limit_th(bus_limit_th), .enter_sleep(enter_sleep),
    .wdt_fault_pulse(wdt_fault_pulse), .switches_hiz(switches_hiz));

  mdc_host_model i_mdc_host_model (.core_clk(core_clk), .run(host_run), .use_pin(host_pin),
    .period(host_per), .tick_pin(tick_pin), .tick_bus(tick_bus));

  // clock
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  // count fault pulses
  always @(posedge core_clk)
    if (wdt_fault_pulse === 1'b1)
      pulses++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic tk(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // this wait ends when waitrequest is sampled low; the hang guard stops a wait that never ends
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [13:0] a, input logic [31:0] ex, input logic [31:0] msk);
    bus(1'b0, a, 32'h00000000);
    chk(nm, ex, q & msk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard
  initial
  begin
    tk(30000);
    failures++;
    finish_test();
  end

  initial
  begin
    tk(4);
    rst <= 1'b0;
    tk(1);
    chk("dev_rst", 32'h00000000, dev_cfg);
    chk("peri_rst", 32'h40000000, peri_cfg);
    chk("dither_rst", 0, dither_on);
    rd("dev_rd", a_dev, 32'h00000000, 32'hFFFFFFFF);
    rd("peri_rd", a_peri, 32'h40000000, 32'hFFFFFFFF);
    bus(1'b1, a_dev, 32'hFFFFFFEF);
    bus(1'b1, 14'h0100, 32'h00000000);
    rd("dev_rsvd", a_dev, 32'h7FFFFFEF, 32'hFFFFFFFF);
    rd("unmapped", 14'h0100, 32'h00000000, 32'hFFFFFFFF);
    // limit codes, enable and dither bit
    for (int c = 0; c < 16; c++)
    begin
      bus(1'b1, a_peri, {1'b1, c[1], 4'hF, 4'(c), c[0], 21'h1FFFFF});
      tk(2);
      chk("limit_th", c == 0 ? 10 : c == 1 ? 20 : 40 * ((c > 13 ? 13 : c) - 1), bus_limit_th);
      chk("limit_on", c[0], bus_limit_on);
      chk("dither_on", !c[1], dither_on);
      rd("peri_rsvd", a_peri, {1'b0, c[1], 4'h0, 4'(c), c[0], 21'h0}, 32'hFFFFFFFF);
    end
    // random device settings, watchdog kept off
    for (int i = 0; i < 16; i++)
    begin
      v = rnd() & 32'h7FFFFFEF;
      if (i[0])
        v[10:8] = 3'h7;
      bus(1'b1, a_dev, v);
      tk(2);
      chk("dev_cfg", v, dev_cfg);
      chk("ext_clk", v[8] && v[10:9] == 2'h3, ext_clk_used);
      chk("ext_rate", 32'h8 << v[7:5], ext_rate_khz);
    end
    // duty in every reference mode
    for (int i = 0; i < 12; i++)
    begin
      v = rnd();
      bus(1'b1, a_dev, {1'b0, v[30:16] | 15'h0001, 16'h0000});
      speed_mode <= 2'(i);
      meas_freq <= v[14:0];
      meas_strobe <= 1'b1;
      tk(1);
      meas_strobe <= 1'b0;
      n = 0;
      while (duty_valid !== 1'b1 && n < 25)
      begin
        tk(1);
        n++;
      end
      chk("duty_valid", i % 4 == 3, n < 25);
      e = (v[14:0] >= (v[30:16] | 15'h0001)) ? 65535 : (longint'(v[14:0]) * 65536) / (v[30:16] | 15'h0001);
      if (i % 4 == 3)
        chk("duty", 32'(e), duty);
    end
    // sleep entry for each delay code
    for (int c = 0; c < 4; c++)
    begin
      lim = s_cyc[c];
      bus(1'b1, a_dev, 32'(c) << 14);
      ref_low <= 1'b1;
      tk(lim - 3);
      ref_low <= 1'b0;
      tk(6);
      chk("short_low", 0, enter_sleep);
      ref_low <= 1'b1;
      n = 0;
      while (enter_sleep !== 1'b1 && n < lim + 8)
      begin
        tk(1);
        n++;
      end
      chk("sleep_time", 1, n >= lim && n <= lim + 5);
      ref_low <= 1'b0;
      tk(6);
      chk("wake", 0, enter_sleep);
    end
    // watchdog: sources, intervals, fault actions, wrong source
    for (int i = 0; i < 5; i++)
    begin
      lim = i[0] ? p_cyc[i % 4] : b_cyc[i % 4];
      host_pin <= i[0] ^ (i == 4);
      host_per <= 16'(lim / 2);
      host_run <= 1'b1;
      bus(1'b1, a_dev, {27'h0, 1'b1, 2'(i), i[0], i[1]});
      pulses = 0;
      tk(3 * lim);
      chk("early_fault", i == 4, pulses > 0);
      host_run <= 1'b0;
      pulses = 0;
      n = 0;
      while (pulses == 0 && n < lim + 8)
      begin
        tk(1);
        n++;
      end
      chk("expiry", 1, n <= lim + 6);
      tk(2);
      chk("hiz", i[1], switches_hiz);
      chk("stat_port", {30'h0, i[1], 1'b1}, {30'h0, status[1:0]});
      rd("stat_set", a_stat, {30'h0, i[1], 1'b1}, 32'h3);
      bus(1'b1, a_dev, 32'h00000000);
      bus(1'b1, a_stat, 32'h00000003);
      rd("stat_clr", a_stat, 32'h0, 32'h3);
      pulses = 0;
      tk(2 * lim);
      chk("disabled", 0, pulses);
      chk("hiz_clr", 0, switches_hiz);
    end
    finish_test();
  end
endmodule
